// ===== pkg/pcg_defs.svh
// Purpose: constants of the pin control and gpio block
// Assumes: avalon byte addresses, one 32-bit word per register
// Notes:   offsets, fields, reset values and word codes live here; event and mux codes live in pcg_pkg
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH
`define PCG_NPINS        32
`define PCG_AW           16
`define PCG_GPIO_BASE    16'h0000
`define PCG_GPIO_ALIAS   16'h8000
`define PCG_GPIO_MASK    16'hFFE0
`define PCG_CTRL_BASE    16'h1000
`define PCG_STAT_OFS     16'h1080
`define PCG_MASK_OFS     16'h1084
`define PCG_IDX_OUT      3'h0
`define PCG_IDX_SET      3'h1
`define PCG_IDX_CLR      3'h2
`define PCG_IDX_TGL      3'h3
`define PCG_IDX_IN       3'h4
`define PCG_IDX_DIR      3'h5
`define PCG_F_MUX_LO     0
`define PCG_F_PULL_EN    4
`define PCG_F_PULL_UP    5
`define PCG_F_DRIVE_HI   6
`define PCG_F_FILT_EN    7
`define PCG_F_OPEN_DRAIN 8
`define PCG_F_EVT_LO     16
`define PCG_CTRL_WMASK   32'h000F01F7
`define PCG_CTRL_RESET   32'h00000000
`endif

// ===== pkg/pcg_pkg.sv
// Purpose: types of the pin control and gpio block
// Assumes: nothing beyond the constants header
// Notes:   event codes follow the usual disabled/dma/interrupt grouping
package pcg_pkg;
    typedef enum logic [2:0] {
        function_select_analog      = 3'h0,
        function_select_general_io  = 3'h1,
        function_select_alt2        = 3'h2,
        function_select_alt3        = 3'h3,
        function_select_alt4        = 3'h4,
        function_select_alt5        = 3'h5,
        function_select_alt6        = 3'h6,
        function_select_highest_alt = 3'h7
    } pcg_mux_t;
    typedef enum logic [3:0] {
        PCG_EVT_OFF      = 4'h0,
        PCG_EVT_DMA_RISE = 4'h1,
        PCG_EVT_DMA_FALL = 4'h2,
        PCG_EVT_DMA_BOTH = 4'h3,
        PCG_EVT_LVL_LOW  = 4'h8,
        PCG_EVT_IRQ_RISE = 4'h9,
        PCG_EVT_IRQ_FALL = 4'hA,
        PCG_EVT_IRQ_BOTH = 4'hB,
        PCG_EVT_LVL_HIGH = 4'hC
    } pcg_evt_t;
    // pad settings handed to one pad cell
    typedef struct packed {
        logic pull_en;
        logic pull_up;
        logic drive_hi;
        logic filt_en;
    } pcg_pad_t;
    // fast gpio port request
    typedef struct packed {
        logic        en;
        logic        wr;
        logic [2:0]  idx;
        logic [31:0] wdata;
    } pcg_fast_req_t;
endpackage

// ===== src/pcg_port.sv
// Purpose: per-pin mux, pad control, pin events and gpio data registers
// Assumes: single clock mclk, synchronous active-high reset srst
// Notes:   avalon slave answers on the second cycle of every request
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pcg_defs.svh"
module pcg_port
    import pcg_pkg::*;
#(
    parameter int NPINS = `PCG_NPINS
) (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic [`PCG_AW-1:0]    avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    input  wire pcg_fast_req_t         fast_req,
    output logic      [31:0]           fast_rdata,
    input  wire logic [NPINS-1:0]      pad_in,
    output logic      [NPINS-1:0]      pad_out,
    output logic      [NPINS-1:0]      pad_oe,
    output pcg_pad_t  [NPINS-1:0]      pad_cfg,
    output pcg_mux_t  [NPINS-1:0]      pin_mux,
    input  wire logic [NPINS-1:0]      alt_out,
    input  wire logic [NPINS-1:0]      alt_oe,
    output logic      [NPINS-1:0]      alt_in,
    output logic      [NPINS-1:0]      dma_req,
    output logic                       irq,
    output logic                       wake
);
    // per-pin state
    logic [31:0]      ctrl_q [NPINS];
    logic [31:0]      ctrl_d [NPINS];
    logic [NPINS-1:0] pdor_q, pdor_d;
    logic [NPINS-1:0] pddr_q, pddr_d;
    logic [NPINS-1:0] stat_q, stat_d;
    logic [NPINS-1:0] mask_q, mask_d;
    logic [NPINS-1:0] sync1_q, sync2_q, prev_q;
    logic [31:0]      rdata_q, rdata_d;
    logic [31:0]      frd_q, frd_d;
    logic             ack_q, ack_d;
    logic [NPINS-1:0] pin_in, evt, dma_sel, wake_hit;
    logic [31:0]      rd_val;
    logic [NPINS-1:0] wbytes;

    // one event test shared by the clocked and the clockless paths
    function automatic logic evt_hit(input logic [3:0] code, input logic now,
                                     input logic was);
        case (code)
            PCG_EVT_DMA_RISE, PCG_EVT_IRQ_RISE: evt_hit = now & ~was;
            PCG_EVT_DMA_FALL, PCG_EVT_IRQ_FALL: evt_hit = ~now & was;
            PCG_EVT_DMA_BOTH, PCG_EVT_IRQ_BOTH: evt_hit = now ^ was;
            PCG_EVT_LVL_LOW:                    evt_hit = ~now;
            PCG_EVT_LVL_HIGH:                   evt_hit = now;
            default:                            evt_hit = 1'b0;
        endcase
    endfunction

    // output data update; a zero bit in set/clear/toggle leaves the bit alone
    function automatic logic [NPINS-1:0] gpio_out(input logic [2:0] idx,
            input logic [NPINS-1:0] cur, input logic [NPINS-1:0] wd);
        case (idx)
            `PCG_IDX_OUT: gpio_out = wd;
            `PCG_IDX_SET: gpio_out = cur | wd;
            `PCG_IDX_CLR: gpio_out = cur & ~wd;
            `PCG_IDX_TGL: gpio_out = cur ^ wd;
            default:      gpio_out = cur;
        endcase
    endfunction

    // gpio read mux, shared by bus and fast port
    function automatic logic [31:0] gpio_rd(input logic [2:0] idx,
            input logic [NPINS-1:0] dout, input logic [NPINS-1:0] din,
            input logic [NPINS-1:0] dir);
        gpio_rd = 32'h00000000;
        case (idx)
            `PCG_IDX_OUT: gpio_rd[NPINS-1:0] = dout;
            `PCG_IDX_IN:  gpio_rd[NPINS-1:0] = din;
            `PCG_IDX_DIR: gpio_rd[NPINS-1:0] = dir;
            default:      gpio_rd = 32'h00000000;
        endcase
    endfunction

    // decode: gpio answers at base and at the alias
    logic       is_gpio, is_ctrl, is_stat, is_mask, req;
    logic [4:0] ctrl_idx;
    assign req      = avs_read | avs_write;
    assign is_gpio  = ((avs_address & `PCG_GPIO_MASK) == `PCG_GPIO_BASE) ||
                      ((avs_address & `PCG_GPIO_MASK) == `PCG_GPIO_ALIAS);
    assign is_ctrl  = (avs_address[15:7] == 9'(`PCG_CTRL_BASE >> 7)) &&
                      (int'(avs_address[6:2]) < NPINS);
    assign is_stat  = avs_address == `PCG_STAT_OFS;
    assign is_mask  = avs_address == `PCG_MASK_OFS;
    assign ctrl_idx = avs_address[6:2];

    // byte lanes expanded to bit mask for the narrow gpio words
    always_comb begin
        for (int b = 0; b < NPINS; b++) begin
            wbytes[b] = avs_byteenable[b/8];
        end
    end

    // per-pin pad, mux and event logic
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            pin_mux[i] = pcg_mux_t'(ctrl_q[i][`PCG_F_MUX_LO +: 3]);
            // pad settings held in every digital mux; analog parks the pad
            pad_cfg[i].pull_en  = ctrl_q[i][`PCG_F_PULL_EN] &&
                                  pin_mux[i] != function_select_analog;
            pad_cfg[i].pull_up  = ctrl_q[i][`PCG_F_PULL_UP];
            pad_cfg[i].drive_hi = ctrl_q[i][`PCG_F_DRIVE_HI];
            pad_cfg[i].filt_en  = ctrl_q[i][`PCG_F_FILT_EN];
            if (pin_mux[i] == function_select_general_io) begin
                pad_out[i] = pdor_q[i];
                pad_oe[i]  = pddr_q[i];
            end else if (pin_mux[i] == function_select_analog) begin
                pad_out[i] = 1'b0;
                pad_oe[i]  = 1'b0;
            end else begin
                pad_out[i] = alt_out[i];
                pad_oe[i]  = alt_oe[i];
            end
            // open drain: high side off, so the pad only pulls low
            if (ctrl_q[i][`PCG_F_OPEN_DRAIN] && pad_out[i]) begin
                pad_oe[i] = 1'b0;
            end
            pin_in[i]  = (pin_mux[i] != function_select_analog) ? sync2_q[i] : 1'b0;
            alt_in[i]  = pin_in[i];
            evt[i]     = evt_hit(ctrl_q[i][`PCG_F_EVT_LO +: 4], sync2_q[i], prev_q[i]);
            dma_sel[i] = ctrl_q[i][`PCG_F_EVT_LO + 3] == 1'b0;
            // clockless path: raw pin against the held sample
            wake_hit[i] = evt_hit(ctrl_q[i][`PCG_F_EVT_LO +: 4], pad_in[i], prev_q[i]);
        end
    end

    // enabled events go to dma or interrupt; wake needs no clock edge
    assign dma_req = stat_q & dma_sel;
    assign irq     = |(stat_q & mask_q & ~dma_sel);
    assign wake    = |wake_hit;

    // bus read value, taken on the first cycle of a request
    always_comb begin
        rd_val = 32'h00000000;
        if (is_gpio) begin
            rd_val = gpio_rd(avs_address[4:2], pdor_q, pin_in, pddr_q);
        end else if (is_ctrl) begin
            rd_val = ctrl_q[ctrl_idx];
        end else if (is_stat) begin
            rd_val[NPINS-1:0] = stat_q;
        end else if (is_mask) begin
            rd_val[NPINS-1:0] = mask_q;
        end
    end

    // next values of all software-visible state
    always_comb begin
        ctrl_d  = ctrl_q;
        pdor_d  = pdor_q;
        pddr_d  = pddr_q;
        mask_d  = mask_q;
        stat_d  = stat_q;
        rdata_d = rdata_q;
        frd_d   = frd_q;
        ack_d   = req & ~ack_q;
        if (req && !ack_q) begin
            rdata_d = avs_read ? rd_val : 32'h00000000;
        end
        if (avs_write && ack_q) begin
            if (is_gpio) begin
                pdor_d = (gpio_out(avs_address[4:2], pdor_q, avs_writedata[NPINS-1:0])
                          & wbytes) | (pdor_q & ~wbytes);
                if (avs_address[4:2] == `PCG_IDX_DIR) begin
                    pddr_d = (avs_writedata[NPINS-1:0] & wbytes) | (pddr_q & ~wbytes);
                end
            end else if (is_ctrl) begin
                for (int b = 0; b < 4; b++) begin
                    if (avs_byteenable[b]) begin
                        ctrl_d[ctrl_idx][b*8 +: 8] = avs_writedata[b*8 +: 8] &
                                                     8'(`PCG_CTRL_WMASK >> (b*8));
                    end
                end
            end else if (is_mask) begin
                mask_d = (avs_writedata[NPINS-1:0] & wbytes) | (mask_q & ~wbytes);
            end
        end
        // fast port acts in the cycle it is presented, after any bus write
        if (fast_req.en) begin
            frd_d = gpio_rd(fast_req.idx, pdor_d, pin_in, pddr_d);
            if (fast_req.wr) begin
                pdor_d = gpio_out(fast_req.idx, pdor_d, fast_req.wdata[NPINS-1:0]);
                if (fast_req.idx == `PCG_IDX_DIR) begin
                    pddr_d = fast_req.wdata[NPINS-1:0];
                end
            end
        end
        // read clears only the bits it returned, so an event landing between
        // data capture and clear is not lost; a same-cycle event still lands
        if (avs_read && ack_q && is_stat) begin
            stat_d = stat_q & ~rdata_q[NPINS-1:0];
        end
        stat_d = stat_d | evt;
    end

    // registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < NPINS; i++) begin
                ctrl_q[i] <= `PCG_CTRL_RESET;
            end
            pdor_q  <= '0;
            pddr_q  <= '0;
            stat_q  <= '0;
            mask_q  <= '0;
            rdata_q <= 32'h00000000;
            frd_q   <= 32'h00000000;
            ack_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            pdor_q  <= pdor_d;
            pddr_q  <= pddr_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
            frd_q   <= frd_d;
            ack_q   <= ack_d;
        end
    end

    // pin synchroniser; prev holds the last sample for edge tests
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= pad_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = req & ~ack_q;
    assign fast_rdata      = frd_q;
endmodule // pcg_port

// ===== tb/pcg_pad_model.sv
// Purpose: pad and board model on the port pins
// Assumes: bench supplies an external level and enable per pin
// Notes:   a floating pin shows the inverse of the board level
`timescale 1ns/1ps
module pcg_pad_model
    import pcg_pkg::*;
#(
    parameter int NPINS = 32
) (
    input  wire logic     [NPINS-1:0] pad_out,
    input  wire logic     [NPINS-1:0] pad_oe,
    input  wire pcg_pad_t [NPINS-1:0] pad_cfg,
    input  wire logic     [NPINS-1:0] ext_val,
    input  wire logic     [NPINS-1:0] ext_en,
    output logic          [NPINS-1:0] pad_in
);
    // own driver wins, then the board, then the pull; no stale level left
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pad_cfg[i].pull_en) begin
                pad_in[i] = pad_cfg[i].pull_up;
            end else begin
                pad_in[i] = ~ext_val[i];
            end
        end
    end
endmodule // pcg_pad_model

// ===== tb/pcg_port_asserts.sv
// Purpose: bus and pin checks on the port block
// Assumes: single clock domain
// Notes:   pin 0 stands in for every pin to keep the checks cheap
`timescale 1ns/1ps
module pcg_port_asserts
    import pcg_pkg::*;
#(
    parameter int NPINS = 32
) (
    input wire logic             mclk,
    input wire logic             srst,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [31:0]      avs_readdata,
    input wire logic             avs_waitrequest,
    input wire logic [NPINS-1:0] pad_in,
    input wire logic [NPINS-1:0] pad_out,
    input wire logic [NPINS-1:0] pad_oe,
    input wire pcg_pad_t [NPINS-1:0] pad_cfg,
    input wire pcg_mux_t [NPINS-1:0] pin_mux,
    input wire logic [NPINS-1:0] alt_out,
    input wire logic [NPINS-1:0] alt_oe,
    input wire logic [NPINS-1:0] alt_in,
    input wire logic             wake
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // a request opens busy and must close on the next edge
    sequence s_req_open; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_req_done; !avs_waitrequest; endsequence
    property p_ack_next; s_req_open |=> s_req_done; endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus request not answered");
    property p_idle_nowait; !avs_read && !avs_write |-> !avs_waitrequest; endproperty
    a_idle_nowait: assert property (p_idle_nowait) else $error("busy while idle");
    property p_rd_hold; !avs_read && !avs_write |=> $stable(avs_readdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved while idle");
    // analog pin: no drive, no pull, input reads low
    property p_analog; pin_mux[0] == function_select_analog
        |-> !pad_oe[0] && !pad_cfg[0].pull_en && !alt_in[0]; endproperty
    a_analog: assert property (p_analog) else $error("analog pin active");
    property p_alt_drive; pin_mux[0] > function_select_general_io && pad_oe[0]
        |-> pad_out[0] == alt_out[0]; endproperty
    a_alt_drive: assert property (p_alt_drive) else $error("wrong alt data");
    property p_alt_off; pin_mux[0] > function_select_general_io && !alt_oe[0]
        |-> !pad_oe[0]; endproperty
    a_alt_off: assert property (p_alt_off) else $error("pad driven, alt off");
    // two-flop synchroniser: level seen two edges late in any digital mode
    property p_sync; pin_mux[0] != function_select_analog
        |-> alt_in[0] == $past(pad_in[0], 2); endproperty
    a_sync: assert property (p_sync) else $error("input level not synchronised");
    // limitation: a level code held active keeps wake high, so the bench only pulses levels
    property p_wake_idle; $stable(pad_in) [*3] |-> !wake; endproperty
    a_wake_idle: assert property (p_wake_idle) else $error("wake on quiet pins");
endmodule // pcg_port_asserts
bind pcg_port pcg_port_asserts #(.NPINS(NPINS)) pcg_port_asserts_inst (
    .mclk, .srst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .pad_in,
    .pad_out, .pad_oe, .pad_cfg, .pin_mux, .alt_out, .alt_oe, .alt_in, .wake);

// ===== tb/testbench.sv
// Purpose: self-checking bench for the port block
// Assumes: pad model on the pins, bench is the bus master
// Notes:   pins 0,1 gpio, pin 3 mux sweep, pin 4 events
`timescale 1ns/1ps
`include "pcg_defs.svh"
module testbench
    import pcg_pkg::*;
;
    logic          mclk, avs_waitrequest, irq, wake;
    logic          srst = 1'b1;
    logic          avs_read = 1'b0;
    logic          avs_write = 1'b0;
    logic [15:0]   avs_address = 16'h0000;
    logic [31:0]   avs_writedata = 32'h0, avs_readdata, fast_rdata, q;
    logic [31:0]   pad_in, pad_out, pad_oe, alt_in, dma_req;
    logic [31:0]   alt_out = 32'h0, alt_oe = 32'h0, ext_val = 32'h1, ext_en = 32'h11;
    pcg_pad_t [31:0] pad_cfg;
    pcg_mux_t [31:0] pin_mux;
    pcg_fast_req_t fast_req = '0;
    int            fail_count = 0, comparisons = 0;
    pcg_port pcg_port_inst (.mclk, .srst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .fast_req, .fast_rdata, .pad_in, .pad_out, .pad_oe, .pad_cfg, .pin_mux,
        .alt_out, .alt_oe, .alt_in, .dma_req, .irq, .wake);
    pcg_pad_model pcg_pad_model_inst (.pad_out, .pad_oe, .pad_cfg, .ext_val, .ext_en, .pad_in);
    // free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        if (n == 50) fail_count++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic complete_run;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // reset values, unmapped space, analog pin reads low
    task automatic run_reset;
        bus(0, `PCG_CTRL_BASE, 0);
        chk(q, `PCG_CTRL_RESET);
        bus(1, 16'h2000, 32'hFFFFFFFF);
        bus(0, 16'h2000, 0);
        chk(q, 0);
        bus(0, 16'h0010, 0);
        chk(q[0], 0);
        chk(irq, 0);
    endtask
    // every function code, then pad fields kept on a digital alternative
    task automatic run_pad;
        for (int m = 0; m < 8; m++) begin
            bus(1, `PCG_CTRL_BASE + 16'hC, m);
            chk(pin_mux[3], m);
        end
        // mixed field pattern first, so a swapped pad field shows up
        bus(1, `PCG_CTRL_BASE, 32'h00000052);
        chk(pad_cfg[0], 4'hA);
        bus(1, `PCG_CTRL_BASE, 32'h000000F2);
        chk(pad_cfg[0], 4'hF);
        repeat (3) @(posedge mclk);
        bus(0, 16'h0010, 0);
        chk(q[0], 1);
        chk(alt_in[0], 1);
        alt_oe[0] <= 1'b1;
        @(posedge mclk);
        chk({pad_oe[0], pad_out[0]}, 2'h2);
        alt_oe[0] <= 1'b0;
    endtask
    // gpio output via data, set, clear and toggle words and the alias
    task automatic run_gpio;
        bus(1, `PCG_CTRL_BASE, 1);
        bus(1, `PCG_CTRL_BASE + 16'h4, 1);
        bus(1, 16'h0014, 3);
        bus(1, 16'h0000, 1);
        chk({pad_oe[1:0], pad_out[1:0]}, 4'hD);
        bus(1, 16'h0004, 2);
        chk(pad_out[1:0], 2'h3);
        bus(1, 16'h0008, 1);
        chk(pad_out[1:0], 2'h2);
        bus(1, 16'h800C, 3);
        bus(0, 16'h8000, 0);
        chk(q[1:0], 2'h1);
    endtask
    // open-drain pin releases instead of driving high
    task automatic run_od;
        bus(1, `PCG_CTRL_BASE, 32'h00000101);
        chk(pad_oe[0], 0);
        bus(1, 16'h0008, 1);
        chk({pad_oe[0], pad_out[0]}, 2'h2);
        bus(1, `PCG_CTRL_BASE, 1);
    endtask
    // fast port set, then read back one cycle later
    task automatic run_fast;
        fast_req <= '{en: 1'b1, wr: 1'b1, idx: 3'h1, wdata: 32'h3};
        @(posedge mclk);
        fast_req <= '{en: 1'b1, wr: 1'b0, idx: 3'h0, wdata: 32'h0};
        @(posedge mclk);
        fast_req.en <= 1'b0;
        chk(pad_out[1:0], 2'h3);
        @(posedge mclk);
        chk(fast_rdata[1:0], 2'h3);
    endtask
    // one pin-4 transition; status must be sticky and cleared by a read
    task automatic edge_try(input logic v, input logic hit, input logic [3:0] c,
                            input logic mk);
        ext_val[4] <= v;
        #1;
        chk(wake, hit);
        repeat (4) @(posedge mclk);
        chk(irq, hit & c[3] & mk);
        chk(dma_req[4], hit & ~c[3]);
        bus(0, `PCG_STAT_OFS, 0);
        chk(q[4], hit);
        bus(0, `PCG_STAT_OFS, 0);
        chk(q[4], 0);
    endtask
    // level code on pin 4: wake follows the raw level, status stays sticky;
    // the level is only pulsed, so the pins never sit still while active
    task automatic level_try(input logic act, input logic [3:0] c);
        bus(1, `PCG_CTRL_BASE + 16'h10, 32'h00000001);
        ext_val[4] <= ~act;
        repeat (4) @(posedge mclk);
        bus(1, `PCG_CTRL_BASE + 16'h10, {12'h000, c, 16'h0001});
        bus(0, `PCG_STAT_OFS, 0);
        ext_val[4] <= act;
        #1;
        chk(wake, 1);
        repeat (2) @(posedge mclk);
        ext_val[4] <= ~act;
        #1;
        chk(wake, 0);
        repeat (4) @(posedge mclk);
        chk(irq, 1);
        chk(dma_req[4], 0);
        bus(0, `PCG_STAT_OFS, 0);
        chk(q[4], 1);
        bus(0, `PCG_STAT_OFS, 0);
        chk(q[4], 0);
    endtask
    // every edge code, with the interrupt mask off then on
    task automatic run_evt;
        logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB};
        for (int mk = 0; mk < 2; mk++) begin
            bus(1, `PCG_MASK_OFS, mk << 4);
            foreach (codes[i]) begin
                bus(1, `PCG_CTRL_BASE + 16'h10, {12'h000, codes[i], 16'h0001});
                bus(0, `PCG_STAT_OFS, 0);
                edge_try(1'b1, codes[i][0], codes[i], mk[0]);
                edge_try(1'b0, codes[i][1], codes[i], mk[0]);
            end
        end
        // mask for pin 4 is still on here
        level_try(1'b1, 4'hC);
        level_try(1'b0, 4'h8);
    endtask
    // main sequence: 8-cycle reset, then each scenario
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        run_reset;
        run_pad;
        run_gpio;
        run_od;
        run_fast;
        run_evt;
        complete_run;
    end
    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        fail_count++;
        complete_run;
    end
endmodule // testbench
